// [rtl/usart_sync_slave_rx_control.sv]
`timescale 1ns/1ps
module usart_sync_slave_rx_control #(
    parameter int unsigned BIT_CYCLES = serial_port_pkg::ASYNC_BIT_CYCLES,
    parameter int unsigned DEPTH = serial_port_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input logic clk_sys,
    input logic sys_rst,
    // Register port
    input logic [1:0] reg_addr,
    input logic [7:0] reg_wr_data,
    input logic reg_wr_en,
    input logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // Link pins
    input logic ck_in,
    input logic dt_in,
    output logic dt_out,
    output logic dt_oe
);

    localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
    localparam int unsigned FW = serial_port_pkg::FRAME_W;
    localparam int unsigned DW = serial_port_pkg::DATA_W;

    // Control fields.
    logic port_en_ff;
    logic nine_bit_ff;
    logic single_rx_ff;
    logic cont_rx_ff;
    logic addr_det_ff;
    logic overrun_ff;
    logic clk_src_ff;
    logic tx_en_ff;
    logic sync_ff;

    // Link sampling.
    logic ck_lvl;
    logic ck_rise;
    logic ck_fall;
    logic dt_lvl;
    logic dt_rise;
    logic dt_fall;

    // Mode decode.
    logic slave_mode;
    logic rx_dir;
    logic sync_rx_on;
    logic sync_tx_on;
    logic async_rx_on;

    // Synchronous receiver.
    logic [FW-1:0] srx_bits_ff;
    logic [3:0] srx_idx_ff;
    logic srx_done;
    logic [FW-1:0] srx_frame;

    // Asynchronous receiver.
    serial_port_pkg::async_rx_state_type arx_state_ff;
    logic [CW-1:0] arx_cnt_ff;
    logic [3:0] arx_idx_ff;
    logic [FW-1:0] arx_bits_ff;
    logic arx_done_ff;
    logic [3:0] last_idx;

    // Frame into the buffer.
    logic frame_done;
    logic [FW-1:0] frame_bits;
    logic frame_keep;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FW-1:0] fifo_out_data;

    // Transmitter.
    logic [DW-1:0] tx_shift_ff;
    logic [3:0] tx_left_ff;
    logic dt_out_ff;
    logic dt_oe_ff;

    // Register access.
    logic wr_rcv;
    logic wr_tx;
    logic wr_data;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;

    assign wr_rcv = reg_wr_en && (reg_addr == serial_port_pkg::OFS_RCV_STATUS);
    assign wr_tx = reg_wr_en && (reg_addr == serial_port_pkg::OFS_TX_STATUS);
    assign wr_data = reg_wr_en && (reg_addr == serial_port_pkg::OFS_TX_DATA);

    link_pin_sampler #(
        .IDLE_LEVEL(1'b1)
    ) u_ck_sampler (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(ck_in),
        .level(ck_lvl),
        .rise(ck_rise),
        .fall(ck_fall)
    );

    link_pin_sampler #(
        .IDLE_LEVEL(1'b1)
    ) u_dt_sampler (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in(dt_in),
        .level(dt_lvl),
        .rise(dt_rise),
        .fall(dt_fall)
    );

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            port_en_ff <= serial_port_pkg::RCV_STATUS_RESET[serial_port_pkg::RCV_PORT_EN_BIT];
            nine_bit_ff <= serial_port_pkg::RCV_STATUS_RESET[serial_port_pkg::RCV_NINE_BIT];
            single_rx_ff <= serial_port_pkg::RCV_STATUS_RESET[serial_port_pkg::RCV_SINGLE_BIT];
            cont_rx_ff <= serial_port_pkg::RCV_STATUS_RESET[serial_port_pkg::RCV_CONT_BIT];
            addr_det_ff <= serial_port_pkg::RCV_STATUS_RESET[serial_port_pkg::RCV_ADDR_DET_BIT];
        end else if (wr_rcv) begin
            port_en_ff <= reg_wr_data[serial_port_pkg::RCV_PORT_EN_BIT];
            nine_bit_ff <= reg_wr_data[serial_port_pkg::RCV_NINE_BIT];
            single_rx_ff <= reg_wr_data[serial_port_pkg::RCV_SINGLE_BIT];
            cont_rx_ff <= reg_wr_data[serial_port_pkg::RCV_CONT_BIT];
            addr_det_ff <= reg_wr_data[serial_port_pkg::RCV_ADDR_DET_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clk_src_ff <= serial_port_pkg::TX_STATUS_RESET[serial_port_pkg::TX_CLK_SRC_BIT];
            tx_en_ff <= serial_port_pkg::TX_STATUS_RESET[serial_port_pkg::TX_ENABLE_BIT];
            sync_ff <= serial_port_pkg::TX_STATUS_RESET[serial_port_pkg::TX_SYNC_BIT];
        end else if (wr_tx) begin
            clk_src_ff <= reg_wr_data[serial_port_pkg::TX_CLK_SRC_BIT];
            tx_en_ff <= reg_wr_data[serial_port_pkg::TX_ENABLE_BIT];
            sync_ff <= reg_wr_data[serial_port_pkg::TX_SYNC_BIT];
        end
    end

    assign slave_mode = sync_ff && !clk_src_ff;
    assign rx_dir = single_rx_ff || cont_rx_ff;
    assign sync_rx_on = port_en_ff && slave_mode && rx_dir;
    assign sync_tx_on = port_en_ff && slave_mode && !rx_dir && tx_en_ff;
    assign async_rx_on = port_en_ff && !sync_ff && cont_rx_ff;

    assign last_idx = nine_bit_ff ? 4'h8 : 4'h7;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !sync_rx_on) begin
            srx_bits_ff <= '0;
            srx_idx_ff <= '0;
        end else if (ck_rise) begin
            srx_bits_ff[srx_idx_ff] <= dt_lvl;
            srx_idx_ff <= (srx_idx_ff == last_idx) ? 4'h0 : srx_idx_ff + 4'h1;
            if (srx_idx_ff == 4'h0) begin
                srx_bits_ff[FW-1:1] <= '0;
            end
        end
    end

    assign srx_done = sync_rx_on && ck_rise && (srx_idx_ff == last_idx);

    always_comb begin
        srx_frame = srx_bits_ff;
        srx_frame[srx_idx_ff] = dt_lvl;
        if (!nine_bit_ff) begin
            srx_frame[FW-1] = 1'b0;
        end
    end

    // Start is checked at mid-bit so a short low glitch does not open a frame.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !async_rx_on) begin
            arx_state_ff <= serial_port_pkg::RX_IDLE;
            arx_cnt_ff <= '0;
            arx_idx_ff <= '0;
            arx_bits_ff <= '0;
            arx_done_ff <= 1'b0;
        end else begin
            arx_done_ff <= 1'b0;
            if (arx_cnt_ff != '0) begin
                arx_cnt_ff <= arx_cnt_ff - 1'b1;
            end
            case (arx_state_ff)
                serial_port_pkg::RX_IDLE: begin
                    if (dt_fall) begin
                        arx_state_ff <= serial_port_pkg::RX_START;
                        arx_cnt_ff <= CW'(BIT_CYCLES / 2);
                    end
                end
                serial_port_pkg::RX_START: begin
                    if (arx_cnt_ff == '0) begin
                        if (!dt_lvl) begin
                            arx_state_ff <= serial_port_pkg::RX_DATA;
                            arx_cnt_ff <= CW'(BIT_CYCLES - 1);
                            arx_idx_ff <= '0;
                            arx_bits_ff <= '0;
                        end else begin
                            arx_state_ff <= serial_port_pkg::RX_IDLE;
                        end
                    end
                end
                serial_port_pkg::RX_DATA: begin
                    if (arx_cnt_ff == '0) begin
                        arx_bits_ff[arx_idx_ff] <= dt_lvl;
                        arx_cnt_ff <= CW'(BIT_CYCLES - 1);
                        arx_idx_ff <= arx_idx_ff + 4'h1;
                        if (arx_idx_ff == last_idx) begin
                            arx_state_ff <= serial_port_pkg::RX_STOP;
                        end
                    end
                end
                serial_port_pkg::RX_STOP: begin
                    if (arx_cnt_ff == '0) begin
                        arx_done_ff <= 1'b1;
                        arx_state_ff <= serial_port_pkg::RX_IDLE;
                    end
                end
                default: begin
                    arx_state_ff <= serial_port_pkg::RX_IDLE;
                end
            endcase
        end
    end

    assign frame_done = srx_done || arx_done_ff;
    assign frame_bits = srx_done ? srx_frame : arx_bits_ff;

    // address filter, keep all when off, no effect in eight-bit
    assign frame_keep = sync_ff || !nine_bit_ff || !addr_det_ff || frame_bits[FW-1];
    assign fifo_in_valid = frame_done && frame_keep;

    // A frame that finds the buffer full is dropped; the overrun flag tells software.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            overrun_ff <= serial_port_pkg::RCV_STATUS_RESET[serial_port_pkg::RCV_OVERRUN_BIT];
        end else if (fifo_in_valid && !fifo_in_ready) begin
            overrun_ff <= 1'b1;
        end else if (wr_rcv && !reg_wr_data[serial_port_pkg::RCV_CONT_BIT]) begin
            overrun_ff <= 1'b0;
        end
    end

    assign fifo_out_ready = reg_rd_en && (reg_addr == serial_port_pkg::OFS_RCV_BUFFER);

    frame_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .flush(!port_en_ff),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(frame_bits),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // The slave presents each bit ahead of the rising edge at which the master samples it.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !sync_tx_on) begin
            tx_shift_ff <= '0;
            tx_left_ff <= '0;
            dt_out_ff <= 1'b1;
        end else if (wr_data && (tx_left_ff == 4'h0)) begin
            dt_out_ff <= reg_wr_data[0];
            tx_shift_ff <= {1'b0, reg_wr_data[DW-1:1]};
            tx_left_ff <= 4'h8;
        end else if (tx_left_ff != 4'h0) begin
            if (ck_rise) begin
                tx_left_ff <= tx_left_ff - 4'h1;
            end
            if (ck_fall && (tx_left_ff != 4'h8)) begin
                dt_out_ff <= tx_shift_ff[0];
                tx_shift_ff <= {1'b0, tx_shift_ff[DW-1:1]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dt_oe_ff <= 1'b0;
        end else begin
            dt_oe_ff <= sync_tx_on;
        end
    end

    assign dt_out = dt_out_ff;
    assign dt_oe = dt_oe_ff;

    always_comb begin
        nxt_rd_data = 8'h00;
        case (reg_addr)
            serial_port_pkg::OFS_RCV_STATUS: begin
                nxt_rd_data[serial_port_pkg::RCV_PORT_EN_BIT] = port_en_ff;
                nxt_rd_data[serial_port_pkg::RCV_NINE_BIT] = nine_bit_ff;
                nxt_rd_data[serial_port_pkg::RCV_SINGLE_BIT] = single_rx_ff;
                nxt_rd_data[serial_port_pkg::RCV_CONT_BIT] = cont_rx_ff;
                nxt_rd_data[serial_port_pkg::RCV_ADDR_DET_BIT] = addr_det_ff;
                nxt_rd_data[serial_port_pkg::RCV_OVERRUN_BIT] = overrun_ff;
                nxt_rd_data[serial_port_pkg::RCV_NINTH_BIT] = fifo_out_valid && fifo_out_data[FW-1];
            end
            serial_port_pkg::OFS_TX_STATUS: begin
                nxt_rd_data[serial_port_pkg::TX_CLK_SRC_BIT] = clk_src_ff;
                nxt_rd_data[serial_port_pkg::TX_ENABLE_BIT] = tx_en_ff;
                nxt_rd_data[serial_port_pkg::TX_SYNC_BIT] = sync_ff;
                nxt_rd_data[serial_port_pkg::TX_IDLE_BIT] = (tx_left_ff == 4'h0);
            end
            serial_port_pkg::OFS_RCV_BUFFER: begin
                nxt_rd_data = fifo_out_valid ? fifo_out_data[DW-1:0] : 8'h00;
            end
            default: begin
                nxt_rd_data = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data_ff <= 8'h00;
        end else if (reg_rd_en) begin
            rd_data_ff <= nxt_rd_data;
        end else begin
            rd_data_ff <= 8'h00;
        end
    end

    assign reg_rd_data = rd_data_ff;

endmodule : usart_sync_slave_rx_control

// [rtl/serial_port_pkg.sv]
package serial_port_pkg;

    // Register indices on the plain register port.
    localparam logic [1:0] OFS_RCV_STATUS = 2'h0;
    localparam logic [1:0] OFS_TX_STATUS = 2'h1;
    localparam logic [1:0] OFS_RCV_BUFFER = 2'h2;
    localparam logic [1:0] OFS_TX_DATA = 2'h3;

    // Field positions of receive_status_control.
    localparam int unsigned RCV_PORT_EN_BIT = 7;
    localparam int unsigned RCV_NINE_BIT = 6;
    localparam int unsigned RCV_SINGLE_BIT = 5;
    localparam int unsigned RCV_CONT_BIT = 4;
    localparam int unsigned RCV_ADDR_DET_BIT = 3;
    localparam int unsigned RCV_FRAMING_BIT = 2;
    localparam int unsigned RCV_OVERRUN_BIT = 1;
    localparam int unsigned RCV_NINTH_BIT = 0;

    // Field positions of transmit_status_control.
    localparam int unsigned TX_CLK_SRC_BIT = 7;
    localparam int unsigned TX_ENABLE_BIT = 5;
    localparam int unsigned TX_SYNC_BIT = 4;
    localparam int unsigned TX_IDLE_BIT = 1;

    // Reset values.
    localparam logic [7:0] RCV_STATUS_RESET = 8'h00;
    localparam logic [7:0] TX_STATUS_RESET = 8'h00;

    // Frame and buffer shape.
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FRAME_W = 9;
    localparam int unsigned FIFO_DEPTH = 8;

    // Timing: system clock period and asynchronous bit time.
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned ASYNC_BIT_NS = 8680;
    localparam int unsigned ASYNC_BIT_CYCLES = ASYNC_BIT_NS / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } async_rx_state_type;

endpackage : serial_port_pkg

// [rtl/link_pin_sampler.sv]
`timescale 1ns/1ps
module link_pin_sampler #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    // Clock and reset
    input logic clk_sys,
    input logic sys_rst,
    // Raw pin
    input logic pin_in,
    // Filtered level and edges
    output logic level,
    output logic rise,
    output logic fall
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_ff <= IDLE_LEVEL;
            s2_ff <= IDLE_LEVEL;
            s3_ff <= IDLE_LEVEL;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A change counts only once two late stages agree, which rejects one-cycle glitches.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            level_ff <= IDLE_LEVEL;
        end else if (s2_ff == s3_ff) begin
            level_ff <= s3_ff;
        end
    end

    assign level = level_ff;
    assign rise = (s2_ff == s3_ff) && s3_ff && !level_ff;
    assign fall = (s2_ff == s3_ff) && !s3_ff && level_ff;

endmodule : link_pin_sampler

// [rtl/frame_fifo.sv]
`timescale 1ns/1ps
module frame_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input logic clk_sys,
    input logic sys_rst,
    input logic flush,
    // Fill side
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule : frame_fifo

// [sim/usart_rx_ctrl_asserts.sv]
`timescale 1ns/1ps
module usart_rx_ctrl_asserts #(
    parameter int unsigned BIT_CYCLES = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    // Link pins
    input wire logic ck_in,
    input wire logic dt_in,
    input wire logic dt_out,
    input wire logic dt_oe
);
    logic [7:0] rcv_ff;
    logic [7:0] tx_ff;
    logic pen;
    logic sync_on;
    logic master;
    logic rx_on;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // Shadow copies of the control fields, so pin rules can be tied to what software wrote.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rcv_ff <= serial_port_pkg::RCV_STATUS_RESET;
        end else if (reg_wr_en && reg_addr == serial_port_pkg::OFS_RCV_STATUS) begin
            rcv_ff <= reg_wr_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_ff <= serial_port_pkg::TX_STATUS_RESET;
        end else if (reg_wr_en && reg_addr == serial_port_pkg::OFS_TX_STATUS) begin
            tx_ff <= reg_wr_data;
        end
    end
    assign pen = rcv_ff[serial_port_pkg::RCV_PORT_EN_BIT];
    assign sync_on = tx_ff[serial_port_pkg::TX_SYNC_BIT];
    assign master = tx_ff[serial_port_pkg::TX_CLK_SRC_BIT];
    assign rx_on = rcv_ff[serial_port_pkg::RCV_SINGLE_BIT] | rcv_ff[serial_port_pkg::RCV_CONT_BIT];
    sequence s_read(logic [1:0] idx);
        reg_rd_en && reg_addr == idx;
    endsequence
    sequence s_tx_mode;
        pen && sync_on && !master && !rx_on && tx_ff[serial_port_pkg::TX_ENABLE_BIT];
    endsequence
    a_rd_idle_zero:
    assert property (!$past(reg_rd_en) |-> reg_rd_data == 8'h00)
        else $error("read data not zero outside the answer cycle");
    a_ctrl_readback:
    assert property (s_read(serial_port_pkg::OFS_RCV_STATUS)
        |=> (reg_rd_data & 8'hf8) == ($past(rcv_ff) & 8'hf8))
        else $error("receive control fields read back wrong");
    a_tx_readback:
    assert property (s_read(serial_port_pkg::OFS_TX_STATUS)
        |=> (reg_rd_data & 8'hb0) == ($past(tx_ff) & 8'hb0))
        else $error("transmit control fields read back wrong");
    a_oe_port_off:
    assert property ((!pen && !$past(pen)) |-> !dt_oe)
        else $error("data pin driven while port disabled");
    a_oe_async_off:
    assert property ((!sync_on && !$past(sync_on)) |-> !dt_oe)
        else $error("data pin driven in asynchronous mode");
    a_oe_clk_master:
    assert property ((master && $past(master)) |-> !dt_oe)
        else $error("data pin driven outside slave mode");
    a_oe_rx_mode:
    assert property ((rx_on && $past(rx_on)) |-> !dt_oe)
        else $error("data pin driven while receive selected");
    a_oe_tx_mode:
    assert property (s_tx_mode ##1 s_tx_mode |-> dt_oe)
        else $error("data pin not driven in transmit mode");
endmodule : usart_rx_ctrl_asserts

bind usart_sync_slave_rx_control usart_rx_ctrl_asserts #(
    .BIT_CYCLES(BIT_CYCLES),
    .DEPTH(DEPTH)
) chk_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .ck_in(ck_in), .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe)
);

// [sim/sync_master_model.sv]
`timescale 1ns/1ps
module sync_master_model (
    // Clock
    input wire logic clk_sys,
    // Link lines toward the port
    output logic ck_line,
    output logic dt_line,
    // Data line as the master sees it, and the bits taken off it
    input wire logic dt_back,
    output logic [8:0] seen
);
    initial begin
        ck_line = 1'b1;
        dt_line = 1'b1;
    end
    task automatic mark_idle();
        @(posedge clk_sys);
        dt_line <= 1'b1;
    endtask : mark_idle
    task automatic send_sync(input logic [8:0] frame, input int nbits, input int half);
        logic last;
        logic [8:0] bits;
        last = 1'b1;
        bits = 9'h000;
        @(posedge clk_sys);
        for (int i = 0; i < nbits; i++) begin
            ck_line <= 1'b0;
            dt_line <= frame[i];
            last = frame[i];
            repeat (half) @(posedge clk_sys);
            ck_line <= 1'b1;
            repeat (half) @(posedge clk_sys);
            // The slave moves its bit some clocks after a fall, so take it late in high.
            bits[i] = dt_back;
        end
        seen = bits;
        // Released line must not keep showing the last bit.
        dt_line <= ~last;
    endtask : send_sync
    task automatic send_async(input logic [8:0] frame, input int nbits, input int bit_cyc);
        @(posedge clk_sys);
        dt_line <= 1'b0;
        repeat (bit_cyc) @(posedge clk_sys);
        for (int i = 0; i < nbits; i++) begin
            dt_line <= frame[i];
            repeat (bit_cyc) @(posedge clk_sys);
        end
        dt_line <= 1'b1;
        repeat (bit_cyc) @(posedge clk_sys);
    endtask : send_async
endmodule : sync_master_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned BITS = 8;
    logic clk_sys;
    logic sys_rst;
    logic [1:0] reg_addr;
    logic [7:0] reg_wr_data;
    logic reg_wr_en;
    logic reg_rd_en;
    logic [7:0] reg_rd_data;
    logic ck_line;
    logic dt_line;
    logic dt_in;
    logic dt_out;
    logic dt_oe;
    int err_total;
    int check_count;
    logic [31:0] seed;
    logic [7:0] got;
    logic [8:0] seen;
    logic [8:0] fr [9];
    logic [7:0] bad_tx [3] = '{8'h30, 8'hb0, 8'h20};
    logic [7:0] bad_rcv [3] = '{8'h10, 8'h90, 8'ha0};
    logic [7:0] async_rcv [3] = '{8'hd8, 8'hd0, 8'h98};

    assign dt_in = dt_oe ? dt_out : dt_line;
    usart_sync_slave_rx_control #(.BIT_CYCLES(BITS), .DEPTH(serial_port_pkg::FIFO_DEPTH)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .ck_in(ck_line), .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe));
    sync_master_model m (.clk_sys(clk_sys), .ck_line(ck_line), .dt_line(dt_line),
        .dt_back(dt_in), .seen(seen));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
        check_count++;
        if (got_v !== exp_v) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got_v, exp_v);
        end
    endtask : check
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        @(posedge clk_sys);
        d = reg_rd_data;
    endtask : rd
    task automatic cfg(input logic [7:0] tx, input logic [7:0] rcv);
        wr(serial_port_pkg::OFS_TX_STATUS, tx);
        wr(serial_port_pkg::OFS_RCV_STATUS, rcv);
    endtask : cfg
    // Dropping port enable first empties the buffer between scenarios.
    task automatic setup(input logic [7:0] tx, input logic [7:0] rcv);
        wr(serial_port_pkg::OFS_RCV_STATUS, 8'h00);
        cfg(tx, rcv);
    endtask : setup
    // Status must be read before the buffer, since the buffer read pops the head.
    task automatic rd_frame(input logic ninth, input logic [7:0] data);
        rd(serial_port_pkg::OFS_RCV_STATUS, got);
        check({7'h00, got[0]}, {7'h00, ninth});
        rd(serial_port_pkg::OFS_RCV_BUFFER, got);
        check(got, data);
    endtask : rd_frame
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
    initial begin
        err_total = 0;
        check_count = 0;
        seed = 32'hbe53_5f18;
        sys_rst = 1'b1;
        reg_addr = 2'h0;
        reg_wr_data = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(serial_port_pkg::OFS_RCV_STATUS, got);
        check(got, serial_port_pkg::RCV_STATUS_RESET);
        rd(serial_port_pkg::OFS_TX_STATUS, got);
        check(got, serial_port_pkg::TX_STATUS_RESET | 8'h02);
        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            wr(serial_port_pkg::OFS_RCV_STATUS, seed[7:0]);
            rd(serial_port_pkg::OFS_RCV_STATUS, got);
            check(got, seed[7:0] & 8'hf8);
        end
        for (int i = 0; i < 9; i++) begin
            seed = xorshift(seed);
            fr[i] = seed[8:0];
        end
        for (int k = 0; k < 8; k++) begin
            setup(8'h30, {1'b1, fr[k][8], ~k[0] | k[2], k[0], 4'h0});
            m.send_sync(fr[k], fr[k][8] ? 9 : 8, 4);
            repeat (10) @(posedge clk_sys);
            rd_frame(fr[k][8], fr[k][7:0]);
            check({7'h00, dt_oe}, 8'h00);
        end
        for (int k = 0; k < 3; k++) begin
            setup(8'h30, 8'h90);
            cfg(bad_tx[k], bad_rcv[k]);
            m.send_sync(fr[0], 8, 4);
            cfg(8'h30, 8'h90);
            m.send_sync(fr[1], 8, 4);
            repeat (10) @(posedge clk_sys);
            rd_frame(1'b0, fr[1][7:0]);
        end
        setup(8'h30, 8'h90);
        for (int i = 0; i < 9; i++) begin
            m.send_sync(fr[i], 8, 4);
        end
        repeat (10) @(posedge clk_sys);
        rd(serial_port_pkg::OFS_RCV_STATUS, got);
        check({7'h00, got[1]}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            rd_frame(1'b0, fr[i][7:0]);
        end
        wr(serial_port_pkg::OFS_RCV_STATUS, 8'h80);
        rd(serial_port_pkg::OFS_RCV_STATUS, got);
        check({7'h00, got[1]}, 8'h00);
        for (int k = 0; k < 3; k++) begin
            m.mark_idle();
            setup(8'h20, async_rcv[k]);
            m.send_async({1'b0, fr[2][7:0]}, k < 2 ? 9 : 8, BITS);
            m.send_async({1'b1, fr[3][7:0]}, k < 2 ? 9 : 8, BITS);
            repeat (10) @(posedge clk_sys);
            if (k != 0) begin
                rd_frame(1'b0, fr[2][7:0]);
            end
            rd_frame(k < 2, fr[3][7:0]);
        end
        setup(8'h30, 8'h80);
        repeat (4) @(posedge clk_sys);
        check({7'h00, dt_oe}, 8'h01);
        seed = xorshift(seed);
        wr(serial_port_pkg::OFS_TX_DATA, seed[7:0]);
        rd(serial_port_pkg::OFS_TX_STATUS, got);
        check(got, 8'h30);
        check({7'h00, dt_out}, {7'h00, seed[0]});
        m.send_sync(9'h000, 8, 4);
        check(seen[7:0], seed[7:0]);
        rd(serial_port_pkg::OFS_TX_STATUS, got);
        check(got, 8'h32);
        wr(serial_port_pkg::OFS_RCV_STATUS, 8'ha0);
        repeat (4) @(posedge clk_sys);
        check({7'h00, dt_oe}, 8'h00);
        wrap_up();
    end
endmodule : tb_top
